// ===== design/lfb_lcd_frame_blink_ctrl.sv
/*
  lcd frame and blink controller: ladder, update/invert and clock/blink
  registers, lcd waveform and common sequencing, frame boundaries,
  display-data load handshake and blink gating.
  assumes the processor register port is synchronous to i_core_clk and that
  the main configuration fields arrive as plain inputs from their register.
*/
`timescale 1ns/100ps
module lfb_lcd_frame_blink_ctrl #(
	parameter int unsigned TICK_DIV = lfb_pkg::LFB_TICK_DIV
) (
	// clock, reset, enable
	input  wire logic             i_core_clk,
	input  wire logic             i_rst,
	input  wire logic             i_ce,
	// register port
	input  wire logic [7:0]       i_sfr_addr,
	input  wire logic             i_sfr_wr_en,
	input  wire logic [7:0]       i_sfr_wdata,
	output logic      [7:0]       o_sfr_rdata,
	// main configuration fields
	input  wire logic             i_lcd_clk_select,
	input  wire lfb_pkg::lfb_mux_t i_mux_level,
	input  wire logic             i_blink_enable,
	// panel side
	output logic                  o_ext_ladder_select,
	output logic                  o_lcd_wave,
	output logic      [1:0]       o_com_index,
	output logic                  o_frame_start,
	output logic                  o_frame_invert,
	output logic                  o_load_display,
	output logic                  o_display_on,
	output logic                  o_com2_active,
	output logic                  o_com3_active
);
	import lfb_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0]  clock_blink;
		logic        ext_ladder;
		logic        invert_en;
		logic        hold;
		logic        done;
		logic [6:0]  half_cnt;
		logic        wave;
		logic [1:0]  com_idx;
		logic        frame_inv;
		logic        frame_start;
		logic        load;
		logic [11:0] blink_cnt;
		logic        blink_ph;
		logic        display_on;
		logic        com2;
		logic        com3;
		logic [7:0]  rdata;
	} lfb_st_t;

	lfb_st_t st_r;
	lfb_st_t st_nxt;

	// ----------------------------------------------------------------
	// lcd clock ticks
	// ----------------------------------------------------------------
	logic tick_fast;
	logic tick_slow;
	logic tick_sel;

	lfb_tick_div #(
		.DIV (TICK_DIV)
	) u_fast_div (
		.i_core_clk (i_core_clk),
		.i_rst      (i_rst),
		.i_ce       (i_ce),
		.i_step     (1'b1),
		.o_tick     (tick_fast)
	);

	lfb_tick_div #(
		.DIV (LFB_SLOW_DIV)
	) u_slow_div (
		.i_core_clk (i_core_clk),
		.i_rst      (i_rst),
		.i_ce       (i_ce),
		.i_step     (tick_fast),
		.o_tick     (tick_slow)
	);

	// ----------------------------------------------------------------
	// decoded fields
	// ----------------------------------------------------------------
	logic [3:0]     frame_div;
	logic [1:0]     blink_rate;
	lfb_blink_src_t blink_src;
	logic [6:0]     half_len;
	logic [1:0]     com_last;
	logic [11:0]    blink_len_m1;
	logic           hw_blink;

	assign tick_sel   = i_lcd_clk_select ? tick_slow : tick_fast;
	assign frame_div  = st_r.clock_blink[LFB_POS_FRAME_DIV +: 4];
	assign blink_rate = st_r.clock_blink[LFB_POS_BLINK_RATE +: 2];
	assign blink_src  = lfb_blink_src_t'(st_r.clock_blink[LFB_POS_BLINK_SOURCE +: 2]);
	assign hw_blink   = i_blink_enable && blink_src[1];

	// half of one lcd period in selected-clock ticks
	always_comb begin
		half_len = 7'h01;
		com_last = 2'h1;
		unique case (i_mux_level)
			LFB_MUX_3X: begin
				com_last = 2'h2;
				if (frame_div == 4'h0) begin
					half_len = LFB_HALF_MX_FD0;
				end else if (frame_div == 4'h1) begin
					half_len = LFB_HALF_3X_FD1;
				end else begin
					half_len = {3'h0, frame_div} + 7'h01;
				end
			end
			LFB_MUX_4X: begin
				com_last = 2'h3;
				if (frame_div == 4'h0) begin
					half_len = LFB_HALF_MX_FD0;
				end else if (frame_div == 4'h1) begin
					half_len = LFB_HALF_4X_FD1;
				end else begin
					half_len = {3'h0, frame_div} + 7'h01;
				end
			end
			// reserved level runs as 2x so the panel never sees a stopped waveform
			LFB_MUX_2X, LFB_MUX_RSVD: begin
				com_last = 2'h1;
				if (frame_div == 4'h0) begin
					half_len = LFB_HALF_2X_FD0;
				end else begin
					half_len = {2'h0, frame_div, 1'b0} + 7'h02;
				end
			end
		endcase
	end

	// blink phase length
	always_comb begin
		blink_len_m1 = LFB_BLINK_2HZ_M1;
		if (blink_src == LFB_BLINK_RATE) begin
			unique case (blink_rate)
				2'b00: begin
					blink_len_m1 = LFB_BLINK_1HZ_M1;
				end
				2'b01: begin
					blink_len_m1 = LFB_BLINK_HALF_M1;
				end
				2'b10: begin
					blink_len_m1 = LFB_BLINK_THIRD_M1;
				end
				2'b11: begin
					blink_len_m1 = LFB_BLINK_QUART_M1;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	logic wr_clock;
	logic wr_ladder;
	logic wr_update;

	assign wr_clock  = i_sfr_wr_en && (i_sfr_addr == LFB_ADDR_CLOCK_BLINK);
	assign wr_ladder = i_sfr_wr_en && (i_sfr_addr == LFB_ADDR_LADDER);
	assign wr_update = i_sfr_wr_en && (i_sfr_addr == LFB_ADDR_UPDATE_INVERT);

	always_comb begin
		st_nxt             = st_r;
		st_nxt.frame_start = 1'b0;
		st_nxt.load        = 1'b0;

		// register writes; reserved bits are not stored and read as zero
		if (wr_clock) begin
			st_nxt.clock_blink = i_sfr_wdata;
		end
		if (wr_ladder) begin
			st_nxt.ext_ladder = i_sfr_wdata[LFB_BIT_EXT_LADDER];
		end
		if (wr_update) begin
			st_nxt.invert_en = i_sfr_wdata[LFB_BIT_INVERT_EN];
			st_nxt.hold      = i_sfr_wdata[LFB_BIT_HOLD];
			if (i_sfr_wdata[LFB_BIT_HOLD]) begin
				st_nxt.done = 1'b0;
			end
		end

		// lcd waveform, common stepping and frame boundaries
		if (tick_sel) begin
			if (st_r.half_cnt >= half_len - 7'h01) begin
				st_nxt.half_cnt = 7'h00;
				st_nxt.wave     = ~st_r.wave;
				if (st_r.wave) begin
					if (st_r.com_idx >= com_last) begin
						st_nxt.com_idx     = 2'h0;
						st_nxt.frame_start = 1'b1;
						st_nxt.frame_inv   = st_r.invert_en ? ~st_r.frame_inv : 1'b0;
						// data is taken only while hold is clear, one frame at a time
						if (!st_r.hold) begin
							st_nxt.load = 1'b1;
							st_nxt.done = 1'b1;
						end
					end else begin
						st_nxt.com_idx = st_r.com_idx + 2'h1;
					end
				end
			end else begin
				st_nxt.half_cnt = st_r.half_cnt + 7'h01;
			end
		end
		if (!st_r.invert_en) begin
			st_nxt.frame_inv = 1'b0;
		end

		// blink timing always runs from the 2048 Hz tick, whatever clock drives frames
		if (!hw_blink) begin
			st_nxt.blink_cnt = 12'h000;
			st_nxt.blink_ph  = 1'b1;
		end else if (tick_fast) begin
			if (st_r.blink_cnt >= blink_len_m1) begin
				st_nxt.blink_cnt = 12'h000;
				st_nxt.blink_ph  = ~st_r.blink_ph;
			end else begin
				st_nxt.blink_cnt = st_r.blink_cnt + 12'h001;
			end
		end

		// display gating
		if (!i_blink_enable) begin
			st_nxt.display_on = 1'b1;
		end else begin
			unique case (blink_src)
				LFB_BLINK_SW_OFF: begin
					st_nxt.display_on = 1'b0;
				end
				LFB_BLINK_SW_ON: begin
					st_nxt.display_on = 1'b1;
				end
				LFB_BLINK_FIXED, LFB_BLINK_RATE: begin
					st_nxt.display_on = st_r.blink_ph;
				end
			endcase
		end

		// shared pins become commons at the higher levels
		st_nxt.com2 = (i_mux_level == LFB_MUX_3X) || (i_mux_level == LFB_MUX_4X);
		st_nxt.com3 = (i_mux_level == LFB_MUX_4X);

		// registered read; unmapped addresses answer zero
		st_nxt.rdata = 8'h00;
		unique case (i_sfr_addr)
			LFB_ADDR_CLOCK_BLINK: begin
				st_nxt.rdata = st_r.clock_blink;
			end
			LFB_ADDR_LADDER: begin
				st_nxt.rdata[LFB_BIT_EXT_LADDER] = st_r.ext_ladder;
			end
			LFB_ADDR_UPDATE_INVERT: begin
				st_nxt.rdata[LFB_BIT_INVERT_EN]   = st_r.invert_en;
				st_nxt.rdata[LFB_BIT_UPDATE_DONE] = st_r.done;
				st_nxt.rdata[LFB_BIT_HOLD]        = st_r.hold;
			end
			default: begin
				st_nxt.rdata = 8'h00;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			st_r             <= '0;
			st_r.clock_blink <= LFB_RST_CLOCK_BLINK;
			st_r.ext_ladder  <= LFB_RST_LADDER;
			st_r.invert_en   <= LFB_RST_INVERT;
			st_r.hold        <= LFB_RST_HOLD;
			st_r.done        <= LFB_RST_DONE;
			st_r.blink_ph    <= 1'b1;
			st_r.display_on  <= 1'b1;
		end else if (i_ce) begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign o_sfr_rdata         = st_r.rdata;
	assign o_ext_ladder_select = st_r.ext_ladder;
	assign o_lcd_wave          = st_r.wave;
	assign o_com_index         = st_r.com_idx;
	assign o_frame_start       = st_r.frame_start;
	assign o_frame_invert      = st_r.frame_inv;
	assign o_load_display      = st_r.load;
	assign o_display_on        = st_r.display_on;
	assign o_com2_active       = st_r.com2;
	assign o_com3_active       = st_r.com3;

endmodule

// ===== shared/lfb_pkg.sv
/*
  constants, field layouts and timing counts shared by the lcd frame / blink
  controller and its tick divider.
  assumes an 8-bit special-function register space and a 125 MHz core clock.
*/
// What this block does
// - ladder register bit 6 turns the external bias resistor ladder on or off.
// - frame-invert bit 6 set inverts the waveform every other frame; clear never inverts.
// - hardware sets update-done bit 1 once data is taken and a new frame starts.
// - hold bit 0 set stops taking display data from the data registers.
// - after hold clears, data is loaded into the display at the next frame boundary.
// - blink source 00 forces the display off, 01 forces it on.
// - blink source 10 blinks the display at a fixed 2 Hz.
// - blink source 11 uses rate field: 1, 1/2, 1/3 or 1/4 Hz.
// - clock register bits 3 to 0 form the frame divider.
// - 2048 Hz clock, 2x mux: 512/(n+1) Hz, value 0 gives 16 Hz.
// - 2048 Hz clock, 3x/4x mux: 1024/(n+1) Hz, value 1 and 0 special.
// - clock select 0 picks 2048 Hz, 1 picks 128 Hz for frame division; blink timing stays on 2048 Hz.
// - mux level 01 is 2x, 10 is 3x, 11 is 4x; 00 reserved.
// - blinking acts only while the blink enable bit is set.
package lfb_pkg;

	// ----------------------------------------------------------------
	// register addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] LFB_ADDR_CLOCK_BLINK   = 8'h96;
	localparam logic [7:0] LFB_ADDR_LADDER        = 8'h9c;
	localparam logic [7:0] LFB_ADDR_UPDATE_INVERT = 8'hb1;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] LFB_RST_CLOCK_BLINK   = 8'h00;
	localparam logic       LFB_RST_LADDER        = 1'b0;
	localparam logic       LFB_RST_INVERT        = 1'b0;
	localparam logic       LFB_RST_HOLD          = 1'b0;
	localparam logic       LFB_RST_DONE          = 1'b0;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int LFB_BIT_EXT_LADDER   = 6;
	localparam int LFB_BIT_INVERT_EN    = 6;
	localparam int LFB_BIT_UPDATE_DONE  = 1;
	localparam int LFB_BIT_HOLD         = 0;
	localparam int LFB_POS_BLINK_SOURCE = 6;
	localparam int LFB_POS_BLINK_RATE   = 4;
	localparam int LFB_POS_FRAME_DIV    = 0;

	// ----------------------------------------------------------------
	// encodings
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		LFB_BLINK_SW_OFF = 2'b00,
		LFB_BLINK_SW_ON  = 2'b01,
		LFB_BLINK_FIXED  = 2'b10,
		LFB_BLINK_RATE   = 2'b11
	} lfb_blink_src_t;

	typedef enum logic [1:0] {
		LFB_MUX_RSVD = 2'b00,
		LFB_MUX_2X   = 2'b01,
		LFB_MUX_3X   = 2'b10,
		LFB_MUX_4X   = 2'b11
	} lfb_mux_t;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned LFB_CLK_PERIOD_NS = 8;
	localparam int unsigned LFB_LCD_CLK_HZ    = 2048;
	localparam int unsigned LFB_SLOW_CLK_HZ   = 128;
	// core cycles per 2048 Hz tick, rounded down
	localparam int unsigned LFB_TICK_DIV      = 1000000000 / (LFB_CLK_PERIOD_NS * LFB_LCD_CLK_HZ);
	// 2048 Hz ticks per 128 Hz tick
	localparam int unsigned LFB_SLOW_DIV      = LFB_LCD_CLK_HZ / LFB_SLOW_CLK_HZ;

	// lcd half-period lengths in selected-clock ticks
	localparam logic [6:0] LFB_HALF_2X_FD0 = 7'h40;
	localparam logic [6:0] LFB_HALF_MX_FD0 = 7'h20;
	localparam logic [6:0] LFB_HALF_3X_FD1 = 7'h03;
	localparam logic [6:0] LFB_HALF_4X_FD1 = 7'h02;

	// blink phase lengths minus one, in 2048 Hz ticks
	localparam logic [11:0] LFB_BLINK_2HZ_M1   = 12'h1ff;
	localparam logic [11:0] LFB_BLINK_1HZ_M1   = 12'h3ff;
	localparam logic [11:0] LFB_BLINK_HALF_M1  = 12'h7ff;
	localparam logic [11:0] LFB_BLINK_THIRD_M1 = 12'hbff;
	localparam logic [11:0] LFB_BLINK_QUART_M1 = 12'hfff;

endpackage

// ===== design/lfb_tick_div.sv
/*
  free-running divider that emits a one-cycle tick every DIV enabled cycles with i_step high.
  assumes DIV of at least one and a synchronous active-high reset.
*/
`timescale 1ns/100ps
module lfb_tick_div #(
	parameter int unsigned DIV = 16
) (
	// clock and reset
	input  wire logic i_core_clk,
	input  wire logic i_rst,
	input  wire logic i_ce,
	// step input and tick output
	input  wire logic i_step,
	output logic      o_tick
);
	import lfb_pkg::*;

	localparam int W = (DIV > 1) ? $clog2(DIV) : 1;

	typedef struct packed {
		logic [W-1:0] cnt;
		logic         tick;
	} lfb_div_st_t;

	lfb_div_st_t st_r;
	lfb_div_st_t st_nxt;

	always_comb begin
		st_nxt      = st_r;
		st_nxt.tick = 1'b0;
		if (i_step) begin
			if (st_r.cnt == W'(DIV - 1)) begin
				st_nxt.cnt  = '0;
				st_nxt.tick = 1'b1;
			end else begin
				st_nxt.cnt = st_r.cnt + W'(1);
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			st_r <= '0;
		end else if (i_ce) begin
			st_r <= st_nxt;
		end
	end

	assign o_tick = st_r.tick;

endmodule

// ===== sim/lfb_frame_blink_asserts.sv
/*
  checker for the lcd frame / blink controller, bound to its top module.
  assumes the watched ports of that module and the shared package.
*/
`timescale 1ns/100ps
module lfb_frame_blink_asserts (
	// clock and reset
	input wire logic              i_core_clk,
	input wire logic              i_rst,
	input wire logic              i_ce,
	// register port
	input wire logic [7:0]        i_sfr_addr,
	input wire logic              i_sfr_wr_en,
	input wire logic [7:0]        i_sfr_wdata,
	input wire logic [7:0]        o_sfr_rdata,
	// configuration
	input wire lfb_pkg::lfb_mux_t i_mux_level,
	input wire logic              i_blink_enable,
	// panel side
	input wire logic              o_ext_ladder_select,
	input wire logic              o_frame_start,
	input wire logic              o_frame_invert,
	input wire logic              o_load_display,
	input wire logic              o_display_on,
	input wire logic              o_com2_active,
	input wire logic              o_com3_active
);
	import lfb_pkg::*;
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	// ----------------------------------------------------------------
	// shadow of hold and invert bits, rebuilt from the writes
	// ----------------------------------------------------------------
	logic w96, w9c, wb1, hold_q, inv_q;
	assign w96 = i_ce && i_sfr_wr_en && i_sfr_addr == LFB_ADDR_CLOCK_BLINK;
	assign w9c = i_ce && i_sfr_wr_en && i_sfr_addr == LFB_ADDR_LADDER;
	assign wb1 = i_ce && i_sfr_wr_en && i_sfr_addr == LFB_ADDR_UPDATE_INVERT;
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			hold_q <= 1'b0;
			inv_q  <= 1'b0;
		end else if (wb1) begin
			hold_q <= i_sfr_wdata[0];
			inv_q  <= i_sfr_wdata[6];
		end
	end
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	load_in_frame_a: assert property (o_load_display |-> o_frame_start)
		else $error("load pulse outside a frame start");
	ladder_follow_a: assert property (w9c |=> o_ext_ladder_select == $past(i_sfr_wdata[6]))
		else $error("ladder select does not follow its bit");
	sw_off_a: assert property (w96 && i_sfr_wdata[7:6] == 2'b00 && i_blink_enable
		##1 (i_blink_enable && i_ce && !i_sfr_wr_en)[*2] |=> !o_display_on) else $error("display not forced off");
	sw_on_a: assert property (w96 && i_sfr_wdata[7:6] == 2'b01 && i_blink_enable
		##1 (i_blink_enable && i_ce && !i_sfr_wr_en)[*2] |=> o_display_on) else $error("display not forced on");
	blink_off_a: assert property ((!i_blink_enable && i_ce)[*3] |-> o_display_on)
		else $error("display gated while blink disabled");
	hold_clears_done_a: assert property (wb1 && i_sfr_wdata[0] ##1
		(i_sfr_addr == LFB_ADDR_UPDATE_INVERT && !i_sfr_wr_en && i_ce && !o_load_display)
		|=> o_sfr_rdata[1:0] == 2'b01)
		else $error("hold write did not clear done");
	held_no_load_a: assert property (hold_q && $past(hold_q) |-> !o_load_display)
		else $error("display loaded while held");
	com2_lag_a: assert property (!$past(i_rst) && $past(i_ce) |->
		o_com2_active == ($past(i_mux_level) inside {LFB_MUX_3X, LFB_MUX_4X})) else $error("com2 pin role wrong");
	com3_lag_a: assert property (!$past(i_rst) && $past(i_ce) |->
		o_com3_active == ($past(i_mux_level) == LFB_MUX_4X)) else $error("com3 pin role wrong");
	no_invert_a: assert property ((!inv_q && i_ce)[*3] |-> !o_frame_invert)
		else $error("frame inverted while invert off");
	load_seen_c: cover property (o_load_display);
	held_frame_c: cover property (hold_q && o_frame_start);
	invert_rise_c: cover property ($rose(o_frame_invert));
endmodule

bind lfb_lcd_frame_blink_ctrl lfb_frame_blink_asserts u_chk (.i_core_clk, .i_rst, .i_ce, .i_sfr_addr,
	.i_sfr_wr_en, .i_sfr_wdata, .o_sfr_rdata, .i_mux_level, .i_blink_enable, .o_ext_ladder_select,
	.o_frame_start, .o_frame_invert, .o_load_display, .o_display_on, .o_com2_active, .o_com3_active);

// ===== sim/lfb_panel_model.sv
/*
  segment panel stand-in: counts frames and display loads it receives.
  assumes the controller's registered panel outputs on the core clock.
*/
`timescale 1ns/100ps
module lfb_panel_model (
	// clock and reset
	input  wire logic        i_core_clk,
	input  wire logic        i_rst,
	// controller side
	input  wire logic        i_frame_start,
	input  wire logic        i_load_display,
	// counts
	output logic      [15:0] o_frames,
	output logic      [15:0] o_loads
);
	typedef struct packed {
		logic [15:0] frames;
		logic [15:0] loads;
	} lfb_panel_t;
	lfb_panel_t st_r, st_nxt;
	// ----------------------------------------------------------------
	// counters; 16 bits wrap but a run sees far fewer frames
	// ----------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		if (i_frame_start)
			st_nxt.frames = st_r.frames + 16'h0001;
		if (i_load_display)
			st_nxt.loads = st_r.loads + 16'h0001;
	end
	always_ff @(posedge i_core_clk) begin
		if (i_rst)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end
	assign o_frames = st_r.frames;
	assign o_loads  = st_r.loads;
endmodule

// ===== sim/lfb_lcd_frame_blink_ctrl_bench.sv
/*
  self-checking bench for the lcd frame / blink controller.
  assumes the shared package, the checker bind and the panel model.
*/
`timescale 1ns/100ps
module lfb_lcd_frame_blink_ctrl_bench;
	import lfb_pkg::*;
	// short tick keeps blink phases of seconds within the run
	localparam int TD = 2;
	logic             i_core_clk = 1'b0, i_rst = 1'b1, i_ce = 1'b1, i_sfr_wr_en = 1'b0;
	logic             i_lcd_clk_select = 1'b0, i_blink_enable = 1'b0;
	logic      [7:0]  i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00, o_sfr_rdata;
	lfb_mux_t         i_mux_level = LFB_MUX_2X;
	logic             o_ext_ladder_select, o_lcd_wave, o_frame_start, o_frame_invert;
	logic             o_load_display, o_display_on, o_com2_active, o_com3_active, a;
	logic      [1:0]  o_com_index;
	logic      [15:0] frames, loads, l0;
	int               mismatches = 0, num_checks = 0, cyc = 0, n;
	lfb_mux_t         tm[8] = '{LFB_MUX_2X, LFB_MUX_2X, LFB_MUX_2X, LFB_MUX_3X, LFB_MUX_3X, LFB_MUX_4X,
	                            LFB_MUX_4X, LFB_MUX_2X};
	logic      [3:0]  tn[8] = '{4'h1, 4'h0, 4'hf, 4'h1, 4'h0, 4'h1, 4'h5, 4'h1};
	logic             ts[8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};

	lfb_lcd_frame_blink_ctrl #(.TICK_DIV(TD)) uut (.i_core_clk, .i_rst, .i_ce, .i_sfr_addr, .i_sfr_wr_en,
		.i_sfr_wdata, .o_sfr_rdata, .i_lcd_clk_select, .i_mux_level, .i_blink_enable, .o_ext_ladder_select,
		.o_lcd_wave, .o_com_index, .o_frame_start, .o_frame_invert, .o_load_display, .o_display_on,
		.o_com2_active, .o_com3_active);
	lfb_panel_model u_panel (.i_core_clk, .i_rst, .i_frame_start(o_frame_start),
		.i_load_display(o_load_display), .o_frames(frames), .o_loads(loads));

	always #4 i_core_clk = ~i_core_clk;
	always @(posedge i_core_clk) begin
		cyc++;
		if (cyc == 90000) begin
			mismatches++;
			print_verdict;
		end
	end
	// ----------------------------------------------------------------
	// access and compare tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		@(posedge i_core_clk);
		i_sfr_addr  <= ad;
		i_sfr_wdata <= d;
		i_sfr_wr_en <= 1'b1;
		@(posedge i_core_clk);
		i_sfr_wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
		@(posedge i_core_clk);
		i_sfr_addr <= ad;
		@(posedge i_core_clk);
		#1 chk(o_sfr_rdata, exp);
	endtask
	task automatic wfs(output int c);
		c = 0;
		do begin
			@(negedge i_core_clk);
			c++;
		end while (o_frame_start !== 1'b1 && c < 40000);
	endtask
	task automatic wchg(output int c);
		logic v;
		v = o_display_on;
		c = 0;
		do begin
			@(negedge i_core_clk);
			c++;
		end while (o_display_on === v && c < 40000);
	endtask
	function automatic int half(lfb_mux_t m, int d);
		if (m == LFB_MUX_2X)
			return (d == 0) ? 64 : 2 * (d + 1);
		if (d == 0)
			return 32;
		if (d == 1)
			return (m == LFB_MUX_3X) ? 3 : 2;
		return d + 1;
	endfunction
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (8) @(posedge i_core_clk);
		i_rst <= 1'b0;
		rd(8'h96, 8'h00);
		rd(8'h9c, 8'h00);
		rd(8'hb1, 8'h00);
		wr(8'h9c, 8'h40);
		rd(8'h9c, 8'h40);
		chk(o_ext_ladder_select, 1'b1);
		wr(8'h9c, 8'h00);
		rd(8'h9c, 8'h00);
		chk(o_ext_ladder_select, 1'b0);
		wr(8'h96, 8'hff);
		rd(8'h96, 8'hff);
		wr(8'h97, 8'hff);
		rd(8'h97, 8'h00);
		wr(8'hb1, 8'hff);
		rd(8'hb1, 8'h41);
		for (int i = 0; i < 8; i++) begin
			wr(8'h96, {4'h0, tn[i]});
			i_mux_level      <= tm[i];
			i_lcd_clk_select <= ts[i];
			wfs(n);
			wfs(n);
			wfs(n);
			chk(n, half(tm[i], tn[i]) * 2 * (int'(tm[i]) + 1) * TD * (ts[i] ? 16 : 1));
			chk({o_com3_active, o_com2_active}, (tm[i] == LFB_MUX_4X) ? 2'b11 : {1'b0, tm[i] == LFB_MUX_3X});
		end
		wr(8'h96, 8'h01);
		i_lcd_clk_select <= 1'b0;
		i_mux_level      <= LFB_MUX_2X;
		wr(8'hb1, 8'h01);
		rd(8'hb1, 8'h01);
		l0 = loads;
		wfs(n);
		wfs(n);
		chk(loads, l0);
		rd(8'hb1, 8'h01);
		wr(8'hb1, 8'h00);
		// a frame boundary on the clearing edge itself still sees hold set
		@(posedge i_core_clk);
		wfs(n);
		chk(o_load_display, 1'b1);
		rd(8'hb1, 8'h02);
		wr(8'hb1, 8'h01);
		rd(8'hb1, 8'h01);
		wr(8'hb1, 8'h40);
		wfs(n);
		wfs(n);
		a = o_frame_invert;
		wfs(n);
		chk(a ^ o_frame_invert, 1'b1);
		wr(8'hb1, 8'h00);
		i_blink_enable <= 1'b1;
		wfs(n);
		wfs(n);
		chk(o_frame_invert, 1'b0);
		wr(8'h96, 8'h41);
		repeat (4) @(negedge i_core_clk);
		chk(o_display_on, 1'b1);
		wr(8'h96, 8'h01);
		repeat (4) @(negedge i_core_clk);
		chk(o_display_on, 1'b0);
		wr(8'h96, 8'h81);
		// first phase after leaving forced mode is short by up to one tick
		wchg(n);
		wchg(n);
		wchg(n);
		chk(n, 512 * TD);
		for (int r = 0; r < 4; r++) begin
			wr(8'h96, {2'b11, 2'(r), 4'h1});
			wchg(n);
			wchg(n);
			chk(n, 1024 * (r + 1) * TD);
		end
		wr(8'h96, 8'h01);
		i_blink_enable <= 1'b0;
		repeat (4) @(negedge i_core_clk);
		chk(o_display_on, 1'b1);
		// a low enable must freeze the waveform and swallow a register write
		@(posedge i_core_clk);
		i_ce <= 1'b0;
		@(negedge i_core_clk);
		l0 = {13'h0000, o_lcd_wave, o_com_index};
		wr(8'h9c, 8'h40);
		repeat (100) @(negedge i_core_clk);
		chk({o_lcd_wave, o_com_index}, l0);
		@(posedge i_core_clk);
		i_ce <= 1'b1;
		rd(8'h9c, 8'h00);
		print_verdict;
	end
endmodule
